// [rtl/spc_top.v]
`include "spc_regs.vh"
module spc_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire reference_clock_in,
   input wire transmit_input_clock,
   input wire ref_half_rate,
   input wire [9:0] transmit_character_in,
   output reg [9:0] tx_character_captured,
   output reg tx_character_valid,
   output reg transmit_clock_out,
   output reg transmit_error_flag,
   input wire recovered_clock_in,
   input wire [9:0] recovered_character_in,
   input wire [1:0] selftest_state_in,
   input wire selftest_pass_in,
   output reg [9:0] receive_character_out,
   output reg receive_clock_out_p,
   output reg receive_clock_out_n,
   output reg selftest_status_pin,
   output reg reclocker_powered_down
);
   // control register and fields
   reg [7:0] ctrl_reg;
   wire transmit_clock_select = ctrl_reg[`SPC_CTRL_CKSEL];
   wire transmit_rate_select = ctrl_reg[`SPC_CTRL_RATE];
   wire phase_buffer_reset = ctrl_reg[`SPC_CTRL_PABRST];
   wire reclocker_output_enable_one = ctrl_reg[`SPC_CTRL_ROE1];
   wire reclocker_output_enable_two = ctrl_reg[`SPC_CTRL_ROE2];
   wire [1:0] receive_selftest_control = ctrl_reg[`SPC_CTRL_BIST_HI:`SPC_CTRL_BIST_LO];
   wire rx_half_rate = ctrl_reg[`SPC_CTRL_RXRATE];

   // every pin-side clock and data passes two flops before use
   wire ref_s, txc_s, rec_s, half_s;
   wire [9:0] txd_s, rxd_s;
   wire [1:0] bst_s;
   wire bpass_s;
   spc_sync2 u_sref (.clk(pclk), .rst_n(presetn), .d(reference_clock_in), .q(ref_s));
   spc_sync2 u_stxc (.clk(pclk), .rst_n(presetn), .d(transmit_input_clock), .q(txc_s));
   spc_sync2 u_srec (.clk(pclk), .rst_n(presetn), .d(recovered_clock_in), .q(rec_s));
   spc_sync2 u_shalf (.clk(pclk), .rst_n(presetn), .d(ref_half_rate), .q(half_s));
   spc_sync2 u_sbp (.clk(pclk), .rst_n(presetn), .d(selftest_pass_in), .q(bpass_s));
   genvar gi;
   generate
      for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
         spc_sync2 u_stxd (.clk(pclk), .rst_n(presetn), .d(transmit_character_in[gi]), .q(txd_s[gi]));
         spc_sync2 u_srxd (.clk(pclk), .rst_n(presetn), .d(recovered_character_in[gi]), .q(rxd_s[gi]));
      end
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_bsync
         spc_sync2 u_sbst (.clk(pclk), .rst_n(presetn), .d(selftest_state_in[gi]), .q(bst_s[gi]));
      end
   endgenerate

   // edge finders; data lags its clock by the same two flops so edges line up
   wire ref_r, ref_f, txc_r, rec_r, rec_f;
   spc_edge u_eref (.clk(pclk), .rst_n(presetn), .lvl(ref_s), .rise(ref_r), .fall(ref_f));
   spc_edge u_etxc (.clk(pclk), .rst_n(presetn), .lvl(txc_s), .rise(txc_r), .fall());
   spc_edge u_erec (.clk(pclk), .rst_n(presetn), .lvl(rec_s), .rise(rec_r), .fall(rec_f));

   // write capture edge: dedicated clock rising, or reference edges
   wire ref_cap = ref_r | (half_s & ref_f);
   wire wr_edge = transmit_clock_select ? ref_cap : txc_r;
   // the buffer always drains on the reference character clock
   wire rd_edge = ref_cap;

   // phase-align buffer: small ring, write and read pointers
   localparam PAB_N = 1 << `SPC_PAB_DEPTH_LOG;
   reg [9:0] pab_mem [0:PAB_N-1];
   reg [`SPC_PAB_DEPTH_LOG-1:0] wp_reg, rp_reg;
   reg [`SPC_PAB_DEPTH_LOG:0] fill_reg;
   reg pab_rst_last_reg;
   // centre offset cut to pointer width on purpose; pointers wrap modulo the depth
   localparam [`SPC_PAB_DEPTH_LOG:0] PAB_CTR = `SPC_PAB_CENTER;
   wire [`SPC_PAB_DEPTH_LOG-1:0] pab_ctr_ptr = PAB_CTR[`SPC_PAB_DEPTH_LOG-1:0];
   // re-centre when the buffer reset field goes from 1 to 0
   wire recenter = ~phase_buffer_reset & pab_rst_last_reg;
   wire pab_over = wr_edge & ~rd_edge & (fill_reg == `SPC_PAB_FULL);
   wire pab_under = rd_edge & ~wr_edge & (fill_reg == {(`SPC_PAB_DEPTH_LOG+1){1'b0}});
   wire pab_fault = pab_over | pab_under;
   reg [`SPC_PAB_DEPTH_LOG:0] fill_next;
   always @* begin
      fill_next = fill_reg;
      if (wr_edge & ~rd_edge & ~pab_over) begin
         fill_next = fill_reg + 1'b1;
      end else if (rd_edge & ~wr_edge & ~pab_under) begin
         fill_next = fill_reg - 1'b1;
      end
   end

   // buffer pointers; centre fill absorbs +-two characters of drift
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_reg <= {`SPC_PAB_DEPTH_LOG{1'b0}};
         rp_reg <= {`SPC_PAB_DEPTH_LOG{1'b0}};
         fill_reg <= `SPC_PAB_CENTER;
         pab_rst_last_reg <= 1'b1;
         transmit_error_flag <= 1'b0;
         tx_character_captured <= 10'h000;
         tx_character_valid <= 1'b0;
      end else begin
         pab_rst_last_reg <= phase_buffer_reset;
         tx_character_valid <= 1'b0;
         if (recenter) begin
            rp_reg <= wp_reg - pab_ctr_ptr;
            fill_reg <= `SPC_PAB_CENTER;
            // a fault in the re-centre cycle still wins over the clear
            transmit_error_flag <= pab_fault;
         end else begin
            fill_reg <= fill_next;
            if (pab_fault) begin
               transmit_error_flag <= 1'b1;
            end
            if (wr_edge & ~pab_over) begin
               pab_mem[wp_reg] <= txd_s;
               wp_reg <= wp_reg + 1'b1;
            end
            if (rd_edge & ~pab_under) begin
               tx_character_captured <= pab_mem[rp_reg];
               tx_character_valid <= 1'b1;
               rp_reg <= rp_reg + 1'b1;
            end
         end
      end
   end

   // reference half period in pclk cycles; the midpoint gives the extra toggle for double rate
   reg [7:0] half_cnt_reg;
   reg [7:0] half_per_reg;
   wire ref_any = ref_r | ref_f;
   wire ref_mid = ~ref_any & (half_cnt_reg == {1'b0, half_per_reg[7:1]});
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt_reg <= 8'h00;
         half_per_reg <= 8'h00;
      end else if (ref_any) begin
         half_cnt_reg <= 8'h00;
         half_per_reg <= half_cnt_reg;
      end else if (half_cnt_reg != `SPC_HALF_CNT_MAX) begin
         half_cnt_reg <= half_cnt_reg + 8'h01; // saturates if the reference stops
      end
   end

   // transmit clock out: follows reference, or toggles four times a reference period for double rate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_clock_out <= 1'b0;
      end else if (transmit_rate_select) begin
         if (ref_any | ref_mid) begin
            transmit_clock_out <= ~transmit_clock_out;
         end
      end else begin
         transmit_clock_out <= ref_s;
      end
   end

   // receive side: full rate updates on rising edge, half rate on both
   wire rx_upd = rec_r | (rx_half_rate & rec_f);
   wire bist_on = receive_selftest_control != `SPC_BIST_OFF;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_character_out <= 10'h000;
         receive_clock_out_p <= 1'b0;
         receive_clock_out_n <= 1'b1;
         selftest_status_pin <= 1'b0;
      end else begin
         receive_clock_out_p <= rec_s;
         receive_clock_out_n <= ~rec_s;
         if (rx_upd) begin
            if (bist_on) begin
               // upper bits are don't-care to the host; held at zero
               receive_character_out <= {8'h00, bst_s};
            end else begin
               receive_character_out <= rxd_s;
            end
            if (receive_selftest_control == `SPC_BIST_RECV) begin
               selftest_status_pin <= bpass_s;
            end else begin
               selftest_status_pin <= 1'b0;
            end
         end
      end
   end

   // reclocker power-down status
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reclocker_powered_down <= 1'b1;
      end else begin
         reclocker_powered_down <= ~reclocker_output_enable_one & ~reclocker_output_enable_two;
      end
   end

   // apb slave: zero wait states, error on unmapped address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `SPC_CTRL_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            pready <= 1'b1;
            prdata <= 32'h00000000;
            if (paddr == `SPC_CTRL_ADDR) begin
               if (pwrite) begin
                  ctrl_reg <= pwdata[7:0];
               end else begin
                  prdata <= {24'h000000, ctrl_reg};
               end
            end else if (paddr == `SPC_STAT_ADDR) begin
               prdata <= {29'h00000000, selftest_status_pin, reclocker_powered_down, transmit_error_flag};
               pslverr <= pwrite;
            end else if (paddr == `SPC_RXDATA_ADDR) begin
               prdata <= {21'h000000, tx_character_valid, tx_character_captured};
               pslverr <= pwrite;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule

// [common/spc_regs.vh]
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
// register byte offsets
`define SPC_CTRL_ADDR 12'h000
`define SPC_STAT_ADDR 12'h004
`define SPC_RXDATA_ADDR 12'h008
// control fields
`define SPC_CTRL_CKSEL 0
`define SPC_CTRL_RATE 1
`define SPC_CTRL_PABRST 2
`define SPC_CTRL_ROE1 3
`define SPC_CTRL_ROE2 4
`define SPC_CTRL_BIST_LO 5
`define SPC_CTRL_BIST_HI 6
`define SPC_CTRL_RXRATE 7
// reset: dedicated clock, full rate, buffer reset held on, reclocker off, self-test off (binary 11)
`define SPC_CTRL_RESET 8'h64
// status fields
`define SPC_STAT_TXERR 0
`define SPC_STAT_REPDO 1
`define SPC_STAT_BISTST 2
// self-test control value that makes the status pin valid
`define SPC_BIST_RECV 2'h2
// self-test control value that switches self-test off
`define SPC_BIST_OFF 2'h3
// saturation point of the reference half-period counter
`define SPC_HALF_CNT_MAX 8'hff
// phase buffer geometry
`define SPC_PAB_DEPTH_LOG 2
`define SPC_PAB_CENTER 3'h2
`define SPC_PAB_FULL 3'h4
`endif

// [rtl/spc_sync2.v]
// two flop synchroniser for one level from another domain
module spc_sync2 (
   input wire clk,
   input wire rst_n,
   input wire d,
   output reg q
);
   reg meta_reg;
   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// [rtl/spc_edge.v]
// edge finder on a synchronised clock level
module spc_edge (
   input wire clk,
   input wire rst_n,
   input wire lvl,
   output wire rise,
   output wire fall
);
   reg last_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= lvl;
      end
   end
   assign rise = lvl & ~last_reg;
   assign fall = ~lvl & last_reg;
endmodule

// [testbench/spc_props.sv]
module spc_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire transmit_error_flag,
   input wire [9:0] receive_character_out,
   input wire receive_clock_out_p,
   input wire receive_clock_out_n,
   input wire selftest_status_pin,
   input wire reclocker_powered_down
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh_reg;
   logic [3:0] age_reg;
   logic [3:0] rc_reg;
   wire setup = psel && !penable;
   wire wr_ctrl = setup && pwrite && paddr == 12'h000;
   // control shadow; ages saturate so settle checks wait past a slow link edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 8'h64;
         age_reg <= 4'hf;
         rc_reg <= 4'hf;
      end else begin
         if (wr_ctrl) sh_reg <= pwdata[7:0];
         age_reg <= wr_ctrl ? 4'h0 : age_reg + (age_reg != 4'hf);
         rc_reg <= (wr_ctrl && sh_reg[2] && !pwdata[2]) ? 4'h0 : rc_reg + (rc_reg != 4'hf);
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ANSWER: assert property (setup |=> pready) else $error("no answer after setup");
   AST_REFUSE: assert property (setup && (paddr > 12'h008 || (pwrite && paddr != 12'h000)) |=> pslverr)
      else $error("bad access not refused");
   AST_RDCTRL: assert property (setup && !pwrite && paddr == 12'h000 |=> !pslverr && prdata[7:0] == sh_reg)
      else $error("control readback wrong");
   AST_REPDO: assert property (age_reg > 4'h3 |-> reclocker_powered_down == (sh_reg[4:3] == 2'b00))
      else $error("powered down flag wrong");
   AST_PIN: assert property (age_reg == 4'hf && sh_reg[6:5] != 2'h2 |-> !selftest_status_pin)
      else $error("status pin outside receive mode");
   AST_RXLOW: assert property (age_reg == 4'hf && sh_reg[6:5] != 2'h3 |-> receive_character_out[9:2] == 8'h00)
      else $error("upper bits busy in self-test");
   AST_RXPAIR: assert property (receive_clock_out_p != receive_clock_out_n)
      else $error("receive clocks not complementary");
   AST_STICKY: assert property ($fell(transmit_error_flag) |-> rc_reg < 4'h4)
      else $error("error cleared without recenter");
endmodule
bind spc_top spc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .transmit_error_flag(transmit_error_flag), .receive_character_out(receive_character_out),
   .receive_clock_out_p(receive_clock_out_p), .receive_clock_out_n(receive_clock_out_n),
   .selftest_status_pin(selftest_status_pin), .reclocker_powered_down(reclocker_powered_down));

// [testbench/spc_copro.sv]
module spc_copro (
   input wire logic run,
   input wire logic [9:0] chr,
   output logic ref_clk,
   output logic tx_clk,
   output logic [9:0] tx_chr,
   output logic rx_clk,
   output logic [9:0] rx_chr
);
   timeunit 1ns;
   timeprecision 100ps;
   // link clocks free-run at 200 ns, phases unrelated to pclk and to each other
   initial begin
      ref_clk = 0;
      tx_clk = 0;
      rx_clk = 0;
      rx_chr = 10'h000;
      fork
         forever #100 ref_clk = ~ref_clk;
         #13 forever #100 rx_clk = ~rx_clk;
      join
   end
   // same frequency as the reference, fixed 60 ns offset; stalling it forces a buffer fault while the dedicated clock is selected
   always @(ref_clk) tx_clk <= #60 (ref_clk & run);
   assign tx_chr = chr;
   // new character on every recovered edge so update counts show the output rate
   always @(rx_clk) rx_chr <= rx_chr + 10'h001;
endmodule

// [testbench/spc_top_tb.sv]
module spc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, half, pass_in, run, re;
   logic [11:0] paddr;
   logic [31:0] pwdata, rq;
   logic [1:0] st_in;
   logic [9:0] chr;
   wire rclk, tclk, kclk, rv, tco, terr, rxp, rxn, pin, rpd, pready, pslverr;
   wire [9:0] tchr, kchr, cap, rxo;
   wire [31:0] prdata;
   int n_errors, cmp_count, nt, nv, nr;
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   spc_copro copro_u (.run(run), .chr(chr), .ref_clk(rclk), .tx_clk(tclk), .tx_chr(tchr), .rx_clk(kclk),
      .rx_chr(kchr));
   spc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reference_clock_in(rclk), .transmit_input_clock(tclk), .ref_half_rate(half),
      .transmit_character_in(tchr), .tx_character_captured(cap), .tx_character_valid(rv),
      .transmit_clock_out(tco), .transmit_error_flag(terr), .recovered_clock_in(kclk),
      .recovered_character_in(kchr), .selftest_state_in(st_in), .selftest_pass_in(pass_in),
      .receive_character_out(rxo), .receive_clock_out_p(rxp), .receive_clock_out_n(rxn),
      .selftest_status_pin(pin), .reclocker_powered_down(rpd));
   task wrap_up;
      if (n_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task rng(input string nm, input int v, input int e);
      chk(nm, v >= e - 1 && v <= e + 1, 32'h1);
   endtask
   // one apb transfer; answer taken at the edge where pready is seen high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         wrap_up;
      end
      rq = prdata;
      re = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // counts output activity over 64 cycles, 1600 ns, eight link periods
   task meas;
      logic a;
      logic [9:0] c;
      nt = 0;
      nv = 0;
      nr = 0;
      repeat (64) begin
         a = tco;
         c = rxo;
         @(posedge pclk);
         nt += (a !== tco);
         nv += (rv === 1'b1);
         nr += (c !== rxo);
      end
   endtask
   initial begin
      {presetn, psel, penable, pwrite, half, pass_in, paddr, pwdata, st_in} = 0;
      run = 1;
      chr = 10'h2a5;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      xfer(0, 12'h000, 0);
      chk("ctrl", rq, 32'h64);
      xfer(1, 12'h00c, 0);
      chk("unmapped", re, 1);
      xfer(1, 12'h004, 0);
      chk("ro_write", re, 1);
      for (int k = 0; k < 4; k++) begin
         xfer(1, 12'h000, 32'h64 | k << 3);
         xfer(0, 12'h004, 0);
         chk("rpd", rq[1], k == 0);
      end
      // capture on reference, then on dedicated clock, each after a recenter
      for (int s = 1; s >= 0; s--) begin
         chr <= s ? 10'h15a : 10'h2a5;
         xfer(1, 12'h000, 32'h64 | s);
         xfer(1, 12'h000, 32'h60 | s);
         repeat (100) @(posedge pclk);
         xfer(0, 12'h004, 0);
         chk("txerr_clear", rq[0], 0);
         xfer(0, 12'h008, 0);
         chk("captured", rq[9:0], chr);
         // with the reference selected a stalled dedicated clock must not disturb the buffer
         if (s) begin
            run <= 0;
            repeat (40) @(posedge pclk);
            run <= 1;
            repeat (40) @(posedge pclk);
            xfer(0, 12'h004, 0);
            chk("txerr_refsel", rq[0], 0);
         end
      end
      run <= 0;
      repeat (80) @(posedge pclk);
      run <= 1;
      repeat (80) @(posedge pclk);
      xfer(0, 12'h004, 0);
      chk("txerr_sticky", rq[0], 1);
      xfer(1, 12'h000, 32'h64);
      xfer(1, 12'h000, 32'h60);
      repeat (100) @(posedge pclk);
      xfer(0, 12'h004, 0);
      chk("txerr_recentred", rq[0], 0);
      for (int m = 0; m < 4; m++) begin
         half <= m[1];
         xfer(1, 12'h000, 32'h61 | m[0] << 1 | m[1] << 7);
         repeat (20) @(posedge pclk);
         meas;
         rng("txclk_edges", nt, 16 << m[0]);
         rng("captures", nv, 8 << m[1]);
         rng("rx_updates", nr, 8 << m[1]);
      end
      st_in <= 2'h1;
      pass_in <= 1;
      xfer(1, 12'h000, 32'h40);
      repeat (40) @(posedge pclk);
      chk("bist_low", rxo[1:0], 2'h1);
      chk("bist_pin", pin, 1);
      xfer(1, 12'h000, 32'h00);
      repeat (40) @(posedge pclk);
      chk("pin_off", pin, 0);
      wrap_up;
   end
endmodule
